// *** bench/rru_properties.sv ***
// Port timing checker for the rotate-right unit
`timescale 1ns/1ns
module rru_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata_q,
  input wire logic        pready_q,
  input wire logic        pslverr_q,
  input wire logic [11:0] file_addr_q,
  input wire logic        file_re_q,
  input wire logic        file_we_q,
  input wire logic [7:0]  file_wdata_q,
  input wire logic [7:0]  file_rdata,
  input wire logic        done_q
);
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Bus answers after exactly one wait state
  AST_APB_ONE_WAIT:
    assert property (psel && penable && !pready_q |=> pready_q) else $error("late ready");
  AST_ERR_READY:
    assert property (pslverr_q |-> pready_q) else $error("error without ready");
  // Phase order: read, compute, write, done
  AST_RE_TO_DONE:
    assert property (file_re_q |-> ##3 done_q) else $error("done not three after read");
  AST_WE_AFTER_RE:
    assert property (file_we_q |-> $past(file_re_q, 2)) else $error("write not after read");
  AST_WE_THEN_DONE:
    assert property (file_we_q |=> done_q && !file_we_q) else $error("no done after write");
  AST_RE_ALONE:
    assert property (file_re_q |=> !file_re_q [*3]) else $error("read repeated");
  // Operand address must not drift while the instruction runs
  AST_ADDR_HELD:
    assert property (file_re_q |=> $stable(file_addr_q) [*2]) else $error("address moved");
  AST_WDATA_ROT:
    assert property (file_we_q |-> file_wdata_q[6:0] == $past(file_rdata[7:1], 2))
      else $error("bits not shifted right");
endmodule : rru_properties

bind rru_top rru_properties u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
  .pslverr_q(pslverr_q), .file_addr_q(file_addr_q), .file_re_q(file_re_q),
  .file_we_q(file_we_q), .file_wdata_q(file_wdata_q), .file_rdata(file_rdata),
  .done_q(done_q)
);

// *** bench/tb.sv ***
// Self-checking bench for the rotate-right unit
`timescale 1ns/1ns
module tb;
  typedef struct {
    logic [15:0] op;
    logic [3:0]  bk;
    logic [7:0]  v;
    logic        ci;
    logic [7:0]  r;
    logic        co;
  } rru_row_s;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_q, rd, wacc;
  logic        pready_q, pslverr_q, file_re_q, file_we_q, done_q, er;
  logic [11:0] file_addr_q, fa;
  logic [7:0]  file_wdata_q, file_rdata;
  logic [7:0]  mem [0:4095];
  int          num_errors = 0;
  int          n_tests = 0;
  int          n;
  // Opcode, bank, operand, carry in, result, carry out
  rru_row_s rows [6] = '{'{16'h3012, 4'h5, 8'hE6, 1'b0, 8'h73, 1'b0},
    '{16'h3385, 4'h5, 8'h01, 1'b1, 8'h80, 1'b1}, '{16'h4290, 4'h3, 8'hD7, 1'b1, 8'hEB, 1'b1},
    '{16'h4122, 4'hA, 8'h00, 1'b1, 8'h00, 1'b1}, '{16'h30FF, 4'h2, 8'h00, 1'b1, 8'h80, 1'b0},
    '{16'h3200, 4'h7, 8'h03, 1'b0, 8'h01, 1'b1}};

  always #4 pclk = ~pclk;

  rru_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .file_addr_q(file_addr_q), .file_re_q(file_re_q),
    .file_we_q(file_we_q), .file_wdata_q(file_wdata_q), .file_rdata(file_rdata),
    .done_q(done_q)
  );

  // File memory; outside a read it shows inverted data so stale values cannot pass
  assign file_rdata = file_re_q ? mem[file_addr_q] : ~mem[file_addr_q];
  always @(posedge pclk)
    if (file_we_q)
      mem[file_addr_q] <= file_wdata_q;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // One APB transfer; held until ready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready_q !== 1'b1 && k < 50);
    rd = prdata_q;
    er = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 50)
      num_errors++;
  endtask : apb

  // Counts edges from the start write to the done pulse
  task automatic wait_done;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (done_q !== 1'b1 && n < 20);
  endtask : wait_done

  task automatic end_sim;
    $display("errors=%0d tests=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // Main sequence: reset values, table rows, then odd cases
  initial
  begin
    foreach (mem[i])
      mem[i] = 8'(i);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 1; i < 6; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    wacc = 32'h0;
    foreach (rows[i])
    begin
      fa = rows[i].op[8] ? {rows[i].bk, rows[i].op[7:0]}
                         : {(rows[i].op[7] ? 4'hF : 4'h0), rows[i].op[7:0]};
      mem[fa] = rows[i].v;
      apb(1'b1, 8'h10, {28'h0, rows[i].bk});
      apb(1'b1, 8'h0C, {31'h0, rows[i].ci});
      apb(1'b1, 8'h04, {16'h0, rows[i].op});
      apb(1'b1, 8'h00, 32'h1);
      wait_done();
      chk(n, 5);
      if (!rows[i].op[9])
        wacc = {24'h0, rows[i].r};
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, wacc);
      apb(1'b0, 8'h0C, 32'h0);
      chk(rd, {29'h0, rows[i].r[7], rows[i].r == 8'h0,
               rows[i].op[13] ? rows[i].co : rows[i].ci});
      chk({24'h0, mem[fa]}, {24'h0, rows[i].op[9] ? rows[i].r : rows[i].v});
    end
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    // Unknown opcode: no file traffic and no done, sticky flag set
    apb(1'b1, 8'h04, 32'h5000);
    apb(1'b1, 8'h00, 32'h1);
    n = 0;
    repeat (8)
    begin
      @(posedge pclk);
      if (done_q === 1'b1 || file_re_q === 1'b1)
        n++;
    end
    chk(n, 0);
    apb(1'b0, 8'h0C, 32'h0);
    chk({31'h0, rd[3]}, 32'h1);
    apb(1'b1, 8'h0C, 32'h8);
    apb(1'b0, 8'h0C, 32'h0);
    chk({31'h0, rd[3]}, 32'h0);
    // Instruction writes while busy are dropped
    apb(1'b1, 8'h04, 32'h4012);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h04, 32'h4212);
    wait_done();
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h4012);
    end_sim();
  end

  // Watchdog far beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    end_sim();
  end
endmodule : tb

// *** core/rru_decode.sv ***
// Opcode decoder for the two rotate-right instructions
`timescale 1ns/1ns
`include "rru_defs.svh"

module rru_decode (
  input  wire logic [15:0] opcode,
  input  wire logic [3:0]  bank_ptr,
  output logic             is_valid,
  output logic             is_carry,
  output logic             to_file,
  output logic [11:0]      full_addr
);

  // Opcode class and operand bits
  wire       carry_hit = (opcode[15:10] == `RRU_OPC_CARRY);
  wire       plain_hit = (opcode[15:10] == `RRU_OPC_PLAIN);
  wire       use_bank  = opcode[`RRU_BIT_BANK];
  wire [7:0] faddr     = opcode[7:0];

  // Access bank: low half to bank 0, high half to the top bank
  wire [3:0] acc_bank  = (faddr < `RRU_ACC_SPLIT) ? `RRU_ACC_LO_BANK : `RRU_ACC_HI_BANK;
  wire [3:0] sel_bank  = use_bank ? bank_ptr : acc_bank;

  assign is_valid  = carry_hit | plain_hit;
  assign is_carry  = carry_hit;
  assign to_file   = opcode[`RRU_BIT_DEST];
  assign full_addr = {sel_bank, faddr};

endmodule : rru_decode

// *** core/rru_defs.svh ***
// Offsets, field positions, reset values and timing counts of the rotate-right unit
// What this block does
// - Decode both rotate opcodes, then d, a, address
// - Carry rotate: bit0 to carry, carry to bit7
// - Plain rotate: bit0 to bit7, carry kept
// - Carry rotate sets C,N,Z; plain sets N,Z
// - d=0 writes accumulator, d=1 writes file register
// - a=0 access bank, a=1 bank pointer register
`ifndef RRU_DEFS_SVH
`define RRU_DEFS_SVH

// Register byte offsets on APB
`define RRU_OFF_CTRL      8'h00
`define RRU_OFF_INSTR     8'h04
`define RRU_OFF_WACC      8'h08
`define RRU_OFF_FLAGS     8'h0C
`define RRU_OFF_BANK      8'h10
`define RRU_OFF_INFO      8'h14

// Field positions
`define RRU_CTRL_GO       0
`define RRU_CTRL_BUSY     1
`define RRU_FLAG_C        0
`define RRU_FLAG_Z        1
`define RRU_FLAG_N        2
`define RRU_FLAG_ILL      3

// Opcode fields
`define RRU_OPC_CARRY     6'h0C
`define RRU_OPC_PLAIN     6'h10
`define RRU_BIT_DEST      9
`define RRU_BIT_BANK      8

// Access bank split and upper bank
`define RRU_ACC_SPLIT     8'h80
`define RRU_ACC_HI_BANK   4'hF
`define RRU_ACC_LO_BANK   4'h0

// Reset values
`define RRU_RST_INSTR     16'h0000
`define RRU_RST_WACC      8'h00
`define RRU_RST_FLAGS     4'h0
`define RRU_RST_BANK      4'h0

// Timing: phases per instruction cycle
`define RRU_PHASES        4

`endif

// *** core/rru_pkg.sv ***
// Types shared by the rotate-right unit
package rru_pkg;

  // Instruction cycle phases
  typedef enum logic [2:0] {
    rru_ph_idle = 3'b000,
    rru_ph_q1   = 3'b001,
    rru_ph_q2   = 3'b010,
    rru_ph_q3   = 3'b011,
    rru_ph_q4   = 3'b100
  } rru_phase_e;

  typedef logic [7:0]  rru_byte_t;
  typedef logic [11:0] rru_faddr_t;

endpackage : rru_pkg

// *** core/rru_rotate.sv ***
// Rotate-right datapath with flag outputs
`timescale 1ns/1ns

module rru_rotate (
  input  wire logic [7:0] operand,
  input  wire logic       carry_in,
  input  wire logic       through_carry,
  output logic [7:0]      result,
  output logic            carry_out,
  output logic            neg,
  output logic            zero
);

  // Bits 0 to 6 each take their upper neighbour
  genvar i;
  generate
    for (i = 0; i < 7; i = i + 1)
    begin : g_shift
      assign result[i] = operand[i + 1];
    end
  endgenerate

  // Top bit comes from old carry or from wrapped bit 0
  assign result[7] = through_carry ? carry_in : operand[0];
  assign carry_out = through_carry ? operand[0] : carry_in;
  assign neg       = result[7];
  assign zero      = (result == 8'h00);

endmodule : rru_rotate

// *** core/rru_top.sv ***
// Rotate-right execution slice with APB register access and file port
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "rru_defs.svh"

module rru_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata_q,
  output logic             pready_q,
  output logic             pslverr_q,
  output logic [11:0]      file_addr_q,
  output logic             file_re_q,
  output logic             file_we_q,
  output logic [7:0]       file_wdata_q,
  input  wire logic [7:0]  file_rdata,
  output logic             done_q
);

  // Address match used by every register decode
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr == off);
  endfunction : reg_hit

  // Software-visible state
  logic [15:0]         instr_q;
  logic [7:0]          wacc_q;
  logic                c_q;
  logic                n_q;
  logic                z_q;
  logic                ill_q;
  logic [3:0]          bank_q;

  // Execution state
  rru_pkg::rru_phase_e phase_q;
  rru_pkg::rru_phase_e phase_d;
  logic                op_carry_q;
  logic                op_file_q;
  logic [7:0]          operand_q;
  logic [7:0]          result_q;
  logic                res_c_q;
  logic                res_n_q;
  logic                res_z_q;

  // Decoder and rotator outputs
  logic                dec_valid;
  logic                dec_carry;
  logic                dec_file;
  logic [11:0]         dec_addr;
  logic [7:0]          rot_result;
  logic                rot_c;
  logic                rot_n;
  logic                rot_z;

  // APB phase decoding; one wait state so read data leaves a flop
  wire access    = psel & penable;
  wire first_acc = access & ~pready_q;
  wire wr_fire   = access & pready_q & pwrite;
  wire busy      = (phase_q != rru_pkg::rru_ph_idle);

  wire hit_ctrl  = reg_hit(paddr, `RRU_OFF_CTRL);
  wire hit_instr = reg_hit(paddr, `RRU_OFF_INSTR);
  wire hit_wacc  = reg_hit(paddr, `RRU_OFF_WACC);
  wire hit_flags = reg_hit(paddr, `RRU_OFF_FLAGS);
  wire hit_bank  = reg_hit(paddr, `RRU_OFF_BANK);
  wire hit_info  = reg_hit(paddr, `RRU_OFF_INFO);
  wire mapped    = hit_ctrl | hit_instr | hit_wacc | hit_flags | hit_bank | hit_info;

  // Write strobes per register
  wire wr_ctrl   = wr_fire & hit_ctrl;
  wire wr_instr  = wr_fire & hit_instr & ~busy;
  wire wr_wacc   = wr_fire & hit_wacc;
  wire wr_flags  = wr_fire & hit_flags;
  wire wr_bank   = wr_fire & hit_bank;
  wire go        = wr_ctrl & pwdata[`RRU_CTRL_GO] & ~busy;

  // Read multiplexer; unused upper bits read as zero
  wire [31:0] rd_ctrl  = {30'h0, busy, 1'b0};
  wire [31:0] rd_instr = {16'h0, instr_q};
  wire [31:0] rd_wacc  = {24'h0, wacc_q};
  wire [31:0] rd_flags = {28'h0, ill_q, n_q, z_q, c_q};
  wire [31:0] rd_bank  = {28'h0, bank_q};
  wire [31:0] rd_info  = {29'h0, phase_q};
  wire [31:0] rd_data  = hit_ctrl  ? rd_ctrl  :
                         hit_instr ? rd_instr :
                         hit_wacc  ? rd_wacc  :
                         hit_flags ? rd_flags :
                         hit_bank  ? rd_bank  :
                         hit_info  ? rd_info  : 32'h0000_0000;

  // Phase tags for readability
  wire in_q1 = (phase_q == rru_pkg::rru_ph_q1);
  wire in_q2 = (phase_q == rru_pkg::rru_ph_q2);
  wire in_q3 = (phase_q == rru_pkg::rru_ph_q3);
  wire in_q4 = (phase_q == rru_pkg::rru_ph_q4);

  // Instruction decode from the held program word
  rru_decode u_decode (
    .opcode    (instr_q),
    .bank_ptr  (bank_q),
    .is_valid  (dec_valid),
    .is_carry  (dec_carry),
    .to_file   (dec_file),
    .full_addr (dec_addr)
  );

  // Rotate datapath works on the captured operand
  rru_rotate u_rotate (
    .operand       (operand_q),
    .carry_in      (c_q),
    .through_carry (op_carry_q),
    .result        (rot_result),
    .carry_out     (rot_c),
    .neg           (rot_n),
    .zero          (rot_z)
  );

  // Phase sequencer: four phases make one instruction cycle
  always_comb
  begin
    phase_d = phase_q;
    case (phase_q)
      rru_pkg::rru_ph_idle: phase_d = go ? rru_pkg::rru_ph_q1 : rru_pkg::rru_ph_idle;
      rru_pkg::rru_ph_q1:   phase_d = dec_valid ? rru_pkg::rru_ph_q2 : rru_pkg::rru_ph_idle;
      rru_pkg::rru_ph_q2:   phase_d = rru_pkg::rru_ph_q3;
      rru_pkg::rru_ph_q3:   phase_d = rru_pkg::rru_ph_q4;
      rru_pkg::rru_ph_q4:   phase_d = rru_pkg::rru_ph_idle;
      default:              phase_d = rru_pkg::rru_ph_idle;
    endcase
  end

  // Phase register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase_q <= rru_pkg::rru_ph_idle;
    else
      phase_q <= phase_d;
  end

  // APB handshake and read data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= first_acc;
      pslverr_q <= first_acc & ~mapped;
      if (first_acc)
        prdata_q <= rd_data;
    end
  end

  // Program word, writable only while idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      instr_q <= `RRU_RST_INSTR;
    else if (wr_instr)
      instr_q <= pwdata[15:0];
  end

  // Bank pointer register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bank_q <= `RRU_RST_BANK;
    else if (wr_bank)
      bank_q <= pwdata[3:0];
  end

  // Q1: latch decoded class and destination, present file address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_carry_q  <= 1'b0;
      op_file_q   <= 1'b0;
      file_addr_q <= 12'h000;
      file_re_q   <= 1'b0;
    end
    else
    begin
      file_re_q <= in_q1 & dec_valid;
      if (in_q1 && dec_valid)
      begin
        op_carry_q  <= dec_carry;
        op_file_q   <= dec_file;
        file_addr_q <= dec_addr;
      end
    end
  end

  // Q2: capture the file register operand
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      operand_q <= 8'h00;
    else if (in_q2)
      operand_q <= file_rdata;
  end

  // Q3: hold result and candidate flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result_q <= 8'h00;
      res_c_q  <= 1'b0;
      res_n_q  <= 1'b0;
      res_z_q  <= 1'b0;
    end
    else if (in_q3)
    begin
      result_q <= rot_result;
      res_c_q  <= rot_c;
      res_n_q  <= rot_n;
      res_z_q  <= rot_z;
    end
  end

  // Q3 to Q4: file write strobe runs during Q4 when the file is the target
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      file_we_q    <= 1'b0;
      file_wdata_q <= 8'h00;
    end
    else
    begin
      file_we_q <= in_q3 & op_file_q;
      if (in_q3)
        file_wdata_q <= rot_result;
    end
  end

  // Accumulator: the instruction result beats a same-cycle software write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wacc_q <= `RRU_RST_WACC;
    else if (in_q4 && !op_file_q)
      wacc_q <= result_q;
    else if (wr_wacc)
      wacc_q <= pwdata[7:0];
  end

  // Carry flag: only the through-carry rotate changes it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      c_q <= 1'b0;
    else if (in_q4 && op_carry_q)
      c_q <= res_c_q;
    else if (wr_flags)
      c_q <= pwdata[`RRU_FLAG_C];
  end

  // Negative and zero flags follow both rotates
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      n_q <= 1'b0;
      z_q <= 1'b0;
    end
    else if (in_q4)
    begin
      n_q <= res_n_q;
      z_q <= res_z_q;
    end
    else if (wr_flags)
    begin
      n_q <= pwdata[`RRU_FLAG_N];
      z_q <= pwdata[`RRU_FLAG_Z];
    end
  end

  // Unknown opcode is sticky; set wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ill_q <= 1'b0;
    else if (in_q1 && !dec_valid)
      ill_q <= 1'b1;
    else if (wr_flags && pwdata[`RRU_FLAG_ILL])
      ill_q <= 1'b0;
  end

  // Completion pulse marks the end of the instruction cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_q <= 1'b0;
    else
      done_q <= in_q4;
  end

endmodule : rru_top
